// [rtl/pcf_cfg_forward.sv]
// Purpose: Decode, claim and forward primary configuration cycles
// Assumes: Primary signals synchronous to i_mclk; one data phase per cycle
// Notes:   Forwarded cycles leave as a one-cycle request on o_fwd
`timescale 1ns/10ps
`include "pcf_consts.svh"
module pcf_cfg_forward
  import pcf_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_frame_n,
  input  wire logic        i_irdy_n,
  input  wire logic [31:0] i_ad,
  input  wire logic [3:0]  i_upstream_command_byte_enables,
  input  wire logic        i_upstream_config_select,
  output logic             o_upstream_target_claim_n,
  output logic             o_trdy_n,
  output logic      [31:0] o_ad,
  output logic             o_ad_oe_n,
  output logic             o_fwd_valid,
  output pcf_fwd_type      o_fwd,
  output logic      [7:0]  o_upstream_bus_index,
  output logic      [7:0]  o_downstream_bus_index,
  output logic      [7:0]  o_highest_subtree_bus_index
);
  typedef enum logic [1:0] {PCF_IDLE, PCF_DLY, PCF_DATA} pcf_state_type;

  // ==========================================================
  // Address phase decode
  logic        frame_q;
  logic [7:0]  upstream_bus_index;
  logic [7:0]  downstream_bus_index;
  logic [7:0]  highest_subtree_bus_index;
  wire         addr_phase = frame_q && !i_frame_n;
  wire  [3:0]  cmd        = i_upstream_command_byte_enables;
  wire         is_cfg     = (cmd == `PCF_CMD_CFG_READ) || (cmd == `PCF_CMD_CFG_WRITE);
  wire  [7:0]  bus        = i_ad[`PCF_BUS_HI:`PCF_BUS_LO];
  wire  [4:0]  dev        = i_ad[`PCF_DEV_HI:`PCF_DEV_LO];
  wire  [2:0]  func       = i_ad[`PCF_FUNC_HI:`PCF_FUNC_LO];
  wire  [5:0]  dword      = i_ad[`PCF_REG_HI:`PCF_REG_LO];
  // Special cycle command never matches is_cfg, so it is never claimed
  wire         own_hit    = addr_phase && is_cfg && i_upstream_config_select
                            && (i_ad[1:0] == `PCF_TYPE0) && (func == 3'h0);
  wire         to_second  = (bus == downstream_bus_index);
  wire         to_deeper  = (bus > downstream_bus_index)
                            && (bus <= highest_subtree_bus_index);
  wire         fwd_hit    = addr_phase && is_cfg && (i_ad[1:0] == `PCF_TYPE1)
                            && (to_second || to_deeper);
  wire         special    = to_second && (dev == `PCF_SPECIAL_DEV)
                            && (func == `PCF_SPECIAL_FUNC)
                            && (cmd == `PCF_CMD_CFG_WRITE);

  function automatic logic [15:0] idsel_of(input logic [4:0] d);
    idsel_of = d[4] ? 16'h0000 : (16'h0001 << d[3:0]);
  endfunction

  wire  [31:0] conv_addr  = {idsel_of(dev), 5'h00, func, dword, `PCF_TYPE0};

  // ==========================================================
  // Claim state machine
  pcf_state_type state;
  pcf_state_type next_state;
  logic        own_q;
  logic        write_q;
  logic [5:0]  dword_q;
  pcf_fwd_type fwd_q;
  logic [31:0] hdr_rd;
  wire         done       = (state == PCF_DATA) && !i_irdy_n;
  wire         own_wr     = done && own_q && write_q;
  wire  [3:0]  be         = ~cmd;
  wire         bus_wr     = own_wr && (dword_q == `PCF_BUS_DWORD);
  wire  [31:0] rd_word    = (dword_q == `PCF_BUS_DWORD) ?
                            {hdr_rd[31:24], highest_subtree_bus_index,
                             downstream_bus_index, upstream_bus_index} : hdr_rd;

  always_comb begin
    next_state = state;
    case (state)
      PCF_IDLE: begin
        if (own_hit || fwd_hit) begin
          next_state = PCF_DLY;
        end
      end
      PCF_DLY:  next_state = PCF_DATA;
      PCF_DATA: begin
        if (!i_irdy_n) begin
          next_state = PCF_IDLE;
        end
      end
      default:  next_state = PCF_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    frame_q <= i_srst ? 1'b1 : i_frame_n;
    state   <= i_srst ? PCF_IDLE : next_state;
    if (state == PCF_IDLE) begin
      own_q   <= own_hit;
      write_q <= (cmd == `PCF_CMD_CFG_WRITE);
      dword_q <= dword;
    end
  end

  // ==========================================================
  // Forward request build
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      fwd_q <= '0;
    end else if (state == PCF_IDLE && fwd_hit) begin
      if (special) begin
        fwd_q.kind <= PCF_FWD_SPECIAL;
        fwd_q.cmd  <= `PCF_CMD_SPECIAL;
        fwd_q.addr <= 32'h0000_0000;
      end else if (to_second) begin
        fwd_q.kind <= PCF_FWD_TYPE0;
        fwd_q.cmd  <= cmd;
        fwd_q.addr <= conv_addr;
      end else begin
        fwd_q.kind <= PCF_FWD_TYPE1;
        fwd_q.cmd  <= cmd;
        fwd_q.addr <= i_ad;
      end
    end
  end

  // ==========================================================
  // Outputs and bus-number registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_upstream_target_claim_n <= 1'b1;
      o_trdy_n                  <= 1'b1;
      o_ad_oe_n                 <= 1'b1;
      o_ad                      <= 32'h0000_0000;
      o_fwd_valid               <= 1'b0;
      o_fwd                     <= '0;
    end else begin
      o_upstream_target_claim_n <= !(next_state == PCF_DATA);
      o_trdy_n                  <= !(next_state == PCF_DATA);
      o_ad_oe_n                 <= !((next_state == PCF_DATA) && !write_q);
      if (state == PCF_DLY) begin
        o_ad <= own_q ? rd_word : 32'h0000_0000;
      end
      o_fwd_valid <= done && !own_q;
      if (done && !own_q) begin
        o_fwd      <= fwd_q;
        o_fwd.data <= i_ad;
        o_fwd.be_n <= cmd;
      end
    end
  end

  // Bus numbers kept in flops so decode sees them without a memory read
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      upstream_bus_index        <= `PCF_BUS_RESET;
      downstream_bus_index      <= `PCF_BUS_RESET;
      highest_subtree_bus_index <= `PCF_BUS_RESET;
    end else if (bus_wr) begin
      if (be[0]) upstream_bus_index <= i_ad[7:0];
      if (be[1]) downstream_bus_index <= i_ad[15:8];
      if (be[2]) highest_subtree_bus_index <= i_ad[23:16];
    end
  end

  always_ff @(posedge i_mclk) begin
    o_upstream_bus_index        <= i_srst ? `PCF_BUS_RESET : upstream_bus_index;
    o_downstream_bus_index      <= i_srst ? `PCF_BUS_RESET : downstream_bus_index;
    o_highest_subtree_bus_index <= i_srst ? `PCF_BUS_RESET : highest_subtree_bus_index;
  end

  pcf_hdr_mem u_hdr (
    .i_mclk    (i_mclk),
    .i_rd_addr (state == PCF_IDLE ? dword : dword_q),
    .o_rd_data (hdr_rd),
    .i_wr      (own_wr),
    .i_wr_addr (dword_q),
    .i_wr_be   (be),
    .i_wr_data (i_ad)
  );
endmodule

// [rtl/pcf_consts.svh]
// Purpose: Offsets, field positions, encodings and reset values of the config forwarder
// Assumes: Primary bus is synchronous to i_mclk
// Notes:   Included by the package and by the design modules
`ifndef PCF_CONSTS_SVH
`define PCF_CONSTS_SVH
`define PCF_TYPE0                2'h0
`define PCF_TYPE1                2'h1
`define PCF_BUS_HI               23
`define PCF_BUS_LO               16
`define PCF_DEV_HI               15
`define PCF_DEV_LO               11
`define PCF_FUNC_HI              10
`define PCF_FUNC_LO              8
`define PCF_REG_HI               7
`define PCF_REG_LO               2
`define PCF_IDSEL_BASE           16
`define PCF_OFS_UPSTREAM_BUS     8'h18
`define PCF_OFS_DOWNSTREAM_BUS   8'h19
`define PCF_OFS_SUBTREE_BUS      8'h1A
`define PCF_BUS_DWORD            6'h06
`define PCF_BUS_RESET            8'h00
`define PCF_SPECIAL_DEV          5'h1F
`define PCF_SPECIAL_FUNC         3'h7
`define PCF_CMD_SPECIAL          4'h1
`define PCF_CMD_CFG_READ         4'hA
`define PCF_CMD_CFG_WRITE        4'hB
`define PCF_HDR_WORDS            64
`endif

// [rtl/pcf_hdr_mem.sv]
// Purpose: 64-dword configuration header store with byte writes
// Assumes: One read port and one write port, read data registered
// Notes:   Contents are not reset
`timescale 1ns/10ps
`include "pcf_consts.svh"
module pcf_hdr_mem (
  input  wire logic        i_mclk,
  input  wire logic [5:0]  i_rd_addr,
  output logic      [31:0] o_rd_data,
  input  wire logic        i_wr,
  input  wire logic [5:0]  i_wr_addr,
  input  wire logic [3:0]  i_wr_be,
  input  wire logic [31:0] i_wr_data
);
  logic [31:0] mem [0:`PCF_HDR_WORDS-1];

  always_ff @(posedge i_mclk) begin
    o_rd_data <= mem[i_rd_addr];
    for (int b = 0; b < 4; b++) begin
      if (i_wr && i_wr_be[b]) begin
        mem[i_wr_addr][8*b +: 8] <= i_wr_data[8*b +: 8];
      end
    end
  end
endmodule

// [rtl/pcf_pkg.sv]
// Purpose: Types shared by the config forwarder
// Assumes: pcf_consts.svh defines the numbers
// Notes:   Forward request carries one secondary-side cycle
`include "pcf_consts.svh"
package pcf_pkg;
  typedef enum logic [1:0] {
    PCF_FWD_TYPE0,
    PCF_FWD_TYPE1,
    PCF_FWD_SPECIAL
  } pcf_fwd_kind_type;

  typedef struct packed {
    pcf_fwd_kind_type kind;
    logic [3:0]       cmd;
    logic [31:0]      addr;
    logic [31:0]      data;
    logic [3:0]       be_n;
  } pcf_fwd_type;
endpackage

// [sim/pcf_cfg_forward_bench.sv]
// Purpose: Self-checking bench for pcf_cfg_forward
// Assumes: Tasks play the primary initiator
// Notes:   Forwarded reads skipped; they complete with zero
`timescale 1ns/10ps
`include "pcf_consts.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %0h got %0h", n, e, s); end end
module pcf_cfg_forward_bench
  import pcf_pkg::*;
;
  logic        i_mclk = 1'b0, i_srst = 1'b1, i_frame_n = 1'b1, i_irdy_n = 1'b1;
  logic        i_upstream_config_select = 1'b0;
  logic [31:0] i_ad = 32'h0;
  logic [3:0]  i_upstream_command_byte_enables = 4'h0;
  logic        o_upstream_target_claim_n, o_trdy_n, o_ad_oe_n, o_fwd_valid, seen;
  logic [31:0] o_ad, xr, rdq[$];
  pcf_fwd_type o_fwd, got, e, xf, fq[$];
  logic [7:0]  o_upstream_bus_index, o_downstream_bus_index, o_highest_subtree_bus_index;
  wire [23:0]  buses = {o_upstream_bus_index, o_downstream_bus_index, o_highest_subtree_bus_index};
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [5:0]  rg = 6'h0;
  // ==========
  // Structure
  always #2.5 i_mclk = ~i_mclk;
  pcf_cfg_forward dut_u (.*);
  pcf_sec_sink sink_u (.i_mclk(i_mclk), .i_valid(o_fwd_valid), .i_cyc(o_fwd), .o_seen(seen),
    .o_cyc(got));
  // ==========
  // Watcher
  always @(posedge i_mclk) begin
    if (o_ad_oe_n === 1'b0 && i_irdy_n === 1'b0) begin
      xr = rdq.pop_front();
      `CHK("read data", xr, o_ad)
    end
    if (seen === 1'b1) begin
      xf = fq.pop_front();
      `CHK("forward", xf, got)
    end
  end
  // ==========
  // Primary cycle, one data phase
  task automatic cyc(input logic [31:0] a, input logic [3:0] c, input logic [31:0] d,
                     input logic [3:0] be, input logic s, input logic cl);
    @(posedge i_mclk);
    i_frame_n <= 1'b0;
    i_ad <= a;
    i_upstream_command_byte_enables <= c;
    i_upstream_config_select <= s;
    @(posedge i_mclk);
    i_frame_n <= 1'b1;
    i_irdy_n <= 1'b0;
    i_ad <= d;
    i_upstream_command_byte_enables <= be;
    i_upstream_config_select <= 1'b0;
    @(posedge i_mclk);
    #1 `CHK("claim", !cl, o_upstream_target_claim_n)
    `CHK("ready", !cl, o_trdy_n)
    `CHK("drive", !(cl && c == `PCF_CMD_CFG_READ), o_ad_oe_n)
    @(posedge i_mclk);
    i_irdy_n <= 1'b1;
    i_ad <= ~d;
    @(posedge i_mclk);
  endtask
  task automatic t1(input logic [7:0] b, input logic [4:0] d, input logic [2:0] f,
                    input logic [31:0] dt, input pcf_fwd_kind_type k, input logic cl);
    logic [31:0] a;
    a = {8'h00, b, d, f, rg, 2'h1};
    e = '{k, `PCF_CMD_CFG_WRITE, a, dt, 4'h0};
    if (k == PCF_FWD_TYPE0) e.addr = {(d < 5'h10) ? 16'h1 << d : 16'h0, 5'h0, f, rg, 2'h0};
    if (k == PCF_FWD_SPECIAL) e = '{k, `PCF_CMD_SPECIAL, 32'h0, dt, 4'h0};
    if (cl) fq.push_back(e);
    cyc(a, `PCF_CMD_CFG_WRITE, dt, 4'h0, 1'b0, cl);
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    void'($urandom(48));
    repeat (20) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    `CHK("bus reset", 24'h0, buses)
    cyc(32'h18, `PCF_CMD_CFG_WRITE, 32'h0, 4'h0, 1'b1, 1'b1);
    cyc(32'h18, `PCF_CMD_CFG_WRITE, 32'hFF050201, 4'h8, 1'b1, 1'b1);
    rdq.push_back(32'h00050201);
    cyc(32'h18, `PCF_CMD_CFG_READ, 32'h0, 4'h0, 1'b1, 1'b1);
    `CHK("bus index", 24'h010205, buses)
    cyc(32'h118, `PCF_CMD_CFG_READ, 32'h0, 4'h0, 1'b1, 1'b0);
    cyc(32'h18, `PCF_CMD_CFG_READ, 32'h0, 4'h0, 1'b0, 1'b0);
    cyc(32'h18, `PCF_CMD_SPECIAL, 32'h0, 4'h0, 1'b1, 1'b0);
    repeat (4) begin
      rg = 6'($urandom);
      t1(8'h02, 5'($urandom_range(30)), 3'($urandom), $urandom, PCF_FWD_TYPE0, 1'b1);
    end
    t1(8'h02, 5'h1E, 3'h7, 32'h5A, PCF_FWD_TYPE0, 1'b1);
    t1(8'h02, 5'h0F, 3'h0, 32'h1, PCF_FWD_TYPE0, 1'b1);
    t1(8'h05, 5'h03, 3'h2, $urandom, PCF_FWD_TYPE1, 1'b1);
    t1(8'h06, 5'h03, 3'h2, 32'h0, PCF_FWD_TYPE1, 1'b0);
    t1(8'h01, 5'h03, 3'h2, 32'h0, PCF_FWD_TYPE1, 1'b0);
    t1(8'h02, 5'h1F, 3'h7, 32'hC0DE0042, PCF_FWD_SPECIAL, 1'b1);
    t1(8'h04, 5'h1F, 3'h7, 32'h1234, PCF_FWD_TYPE1, 1'b1);
    repeat (3) @(posedge i_mclk);
    `CHK("pending", 0, fq.size())
    give_verdict();
  end
  // Cuts a hang short
  initial begin
    repeat (2000) @(posedge i_mclk);
    n_mismatch++;
    give_verdict();
  end
endmodule

// [sim/pcf_cfg_forward_sva.sv]
// Purpose: Port assertions for pcf_cfg_forward
// Assumes: Bound to the design top
// Notes:   Bus range taken from the registered copies
`timescale 1ns/10ps
`include "pcf_consts.svh"
module pcf_cfg_forward_sva
  import pcf_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_srst,
  input wire logic        i_frame_n,
  input wire logic        i_irdy_n,
  input wire logic [31:0] i_ad,
  input wire logic [3:0]  i_upstream_command_byte_enables,
  input wire logic        i_upstream_config_select,
  input wire logic        o_upstream_target_claim_n,
  input wire logic        o_trdy_n,
  input wire logic [31:0] o_ad,
  input wire logic        o_ad_oe_n,
  input wire logic        o_fwd_valid,
  input wire pcf_fwd_type o_fwd,
  input wire logic [7:0]  o_upstream_bus_index,
  input wire logic [7:0]  o_downstream_bus_index,
  input wire logic [7:0]  o_highest_subtree_bus_index
);
  // ==========
  // Helpers
  logic            fr_q;
  wire logic       cn = o_upstream_target_claim_n;
  wire logic [7:0] bn = i_ad[23:16];
  // Address phase seen only while no access is claimed
  wire logic       ap = fr_q && !i_frame_n && cn;
  always_ff @(posedge i_mclk) fr_q <= i_frame_n;
  // ==========
  // Assertions
  default clocking dc @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_claim_medium: assert property ($fell(cn) |->
    $past(i_frame_n, 2) == 1'b0 && $past(i_frame_n, 3) == 1'b1) else $error("claim late");
  a_fwd_cause: assert property (o_fwd_valid |->
    $past(cn) == 1'b0 && $past(i_irdy_n) == 1'b0) else $error("forward uncaused");
  a_func_refuse: assert property (ap && i_ad[1:0] == 2'h0 && i_ad[10:8] != 3'h0
    |-> ##2 cn) else $error("function claimed");
  a_select_refuse: assert property (ap && i_ad[1:0] == 2'h0 && !i_upstream_config_select
    |-> ##2 cn) else $error("unselected claimed");
  a_special_refuse: assert property (ap
    && i_upstream_command_byte_enables == `PCF_CMD_SPECIAL |-> ##2 cn) else $error("special");
  a_range_refuse: assert property (ap && i_ad[1:0] == 2'h1 && (bn < o_downstream_bus_index
    || bn > o_highest_subtree_bus_index) |-> ##2 cn) else $error("bus out of range");
  a_idsel_hot: assert property (o_fwd_valid && o_fwd.kind == PCF_FWD_TYPE0 |->
    $onehot0(o_fwd.addr[31:16]) && o_fwd.addr[15:11] == 5'h0) else $error("select line");
  a_special_msg: assert property (o_fwd_valid && o_fwd.kind == PCF_FWD_SPECIAL |->
    o_fwd.cmd == `PCF_CMD_SPECIAL && o_fwd.addr == 32'h0) else $error("special form");
  c_special: cover property (o_fwd_valid && o_fwd.kind == PCF_FWD_SPECIAL);
  c_convert: cover property (o_fwd_valid && o_fwd.kind == PCF_FWD_TYPE0);
  c_own_read: cover property (!o_ad_oe_n && !i_irdy_n);
endmodule
bind pcf_cfg_forward pcf_cfg_forward_sva chk_u (.*);

// [sim/pcf_sec_sink.sv]
// Purpose: Secondary-side target taking forwarded cycles
// Assumes: One cycle per valid pulse
// Notes:   Always accepts at once; no retry modelled
`timescale 1ns/10ps
module pcf_sec_sink
  import pcf_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_valid,
  input  wire pcf_fwd_type i_cyc,
  output logic             o_seen,
  output pcf_fwd_type      o_cyc
);
  // ==========
  // Capture
  always_ff @(posedge i_mclk) begin
    o_seen <= i_valid;
    if (i_valid) o_cyc <= i_cyc;
  end
endmodule
